// [verilog/usart_core.sv]
// USART core: AHB-Lite registers, transmitter, receiver and receive FIFO.
// Assumes I_RXD and I_XCK are asynchronous pins and a single bus master.
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module usart_core import usart_pkg::*; (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  input wire logic I_RXD,
  input wire logic I_XCK,
  output logic O_HREADYOUT,
  output logic [31:0] O_HRDATA,
  output logic O_HRESP,
  output logic O_TXD,
  output logic O_XCK,
  output logic O_XCK_OE,
  output logic O_IRQ_RXC,
  output logic O_IRQ_UDRE,
  output logic O_IRQ_TXC
);

  typedef struct packed {
    logic [1:0] rxd_sync;
    logic ap_write;
    logic rd_wait;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic u2x;
    logic txc;
    logic rx_en;
    logic tx_en;
    logic csz_hi;
    logic tx_b8;
    logic xck_dir;
    logic sync_sel;
    logic par_en;
    logic par_odd;
    logic stop2;
    logic [1:0] csz_lo;
    logic cpol;
    logic [11:0] div;
    logic div_reload;
    tx_state_t tx_st;
    logic tx_buf_v;
    logic [8:0] tx_buf;
    logic [8:0] tx_sh;
    logic tx_par;
    logic [3:0] tx_bi;
    logic tx_sb;
    logic txd;
    rx_state_t rx_st;
    logic [3:0] rx_ph;
    logic [3:0] rx_bi;
    logic [8:0] rx_sh;
    logic rx_par;
    logic rx_pe;
    logic rx_pend;
    logic [ENT_W-1:0] rx_pend_w;
    logic ovr_pend;
    logic [1:0][ENT_W-1:0] fifo;
    logic rd_ptr;
    logic [1:0] cnt;
  } state_t;

  state_t q;
  state_t d;
  logic tx_tick;
  logic rx_tick;
  logic rx_sample;
  logic xck_out;
  logic taken;
  logic [31:0] wd;
  logic [7:0] rd;
  logic [ENT_W-1:0] head;
  logic [3:0] nbits;
  logic [8:0] mask;
  logic s;
  logic bit_now;
  logic start_ok;
  logic [3:0] ph_last;
  logic [3:0] ph_half;
  logic [1:0] cnt_t;
  logic frame_done;
  logic [ENT_W-1:0] word;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock generation.
  // Mode and clock source select.
  usart_clock_gen u_clock_gen (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_div(q.div),
    .i_div_reload(q.div_reload),
    .i_sync_sel(q.sync_sel),
    .i_double_speed(q.u2x),
    .i_xck_master(q.xck_dir),
    .i_clock_polarity(q.cpol),
    .i_xck(I_XCK),
    .o_xck(xck_out),
    .o_tx_tick(tx_tick),
    .o_rx_tick(rx_tick),
    .o_rx_sample(rx_sample)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    wd = I_HWDATA;
    rd = 8'h00;
    nbits = q.csz_hi ? NBITS_MAX : (NBITS_MIN + {2'h0, q.csz_lo});
    mask = 9'h1ff >> (NBITS_MAX - nbits);
    head = q.fifo[q.rd_ptr];
    d.rxd_sync = {q.rxd_sync[0], I_RXD};
    s = q.rxd_sync[1];
    d.div_reload = 1'b0;
    frame_done = 1'b0;
    word = '0;
    start_ok = 1'b0;

    // Bus: data phase of a write.
    if (q.ap_write) begin
      unique case (q.ap_addr)
        OFS_DATA: begin
          if (q.tx_en && !q.tx_buf_v) begin
            d.tx_buf = {q.tx_b8, wd[7:0]};
            d.tx_buf_v = 1'b1;
          end
        end
        OFS_CSA: begin
          d.u2x = wd[CSA_U2X];
          if (wd[CSA_TXC]) begin
            d.txc = 1'b0;
          end
        end
        OFS_CSB: begin
          d.rx_en = wd[CSB_RXEN];
          d.tx_en = wd[CSB_TXEN];
          d.csz_hi = wd[CSB_CSZ_HI];
          d.tx_b8 = wd[CSB_TXB8];
        end
        OFS_CSC: begin
          d.xck_dir = wd[CSC_XDIR];
          d.sync_sel = wd[CSC_SYNC];
          d.par_en = wd[CSC_PEN];
          d.par_odd = wd[CSC_PODD];
          d.stop2 = wd[CSC_STOP2];
          d.csz_lo = wd[CSC_CSZ_MSB:CSC_CSZ_LSB];
          d.cpol = wd[CSC_POL];
        end
        OFS_BDL: begin
          d.div[7:0] = wd[7:0];
          d.div_reload = 1'b1;
        end
        OFS_BDH: begin
          d.div[11:8] = wd[3:0];
        end
        default: begin
        end
      endcase
    end

    // Bus: wait cycle of a read.
    cnt_t = q.cnt;
    if (q.rd_wait) begin
      unique case (q.ap_addr)
        OFS_DATA: begin
          rd = head[7:0];
          if (q.cnt != 2'h0) begin
            d.rd_ptr = ~q.rd_ptr;
            cnt_t = q.cnt - 2'h1;
          end
        end
        OFS_CSA: begin
          rd[CSA_RXC] = (q.cnt != 2'h0);
          rd[CSA_TXC] = q.txc;
          rd[CSA_UDRE] = ~q.tx_buf_v;
          rd[CSA_FE] = head[ENT_FE];
          rd[CSA_DOR] = head[ENT_DOR];
          rd[CSA_PE] = head[ENT_PE];
          rd[CSA_U2X] = q.u2x;
        end
        OFS_CSB: begin
          rd[CSB_RXEN] = q.rx_en;
          rd[CSB_TXEN] = q.tx_en;
          rd[CSB_CSZ_HI] = q.csz_hi;
          rd[CSB_RECEIVED_NINTH_BIT] = head[8];
          rd[CSB_TXB8] = q.tx_b8;
        end
        OFS_CSC: begin
          rd = {q.xck_dir, q.sync_sel, q.par_en, q.par_odd, q.stop2, q.csz_lo, q.cpol};
        end
        OFS_BDL: begin
          rd = q.div[7:0];
        end
        OFS_BDH: begin
          rd = {4'h0, q.div[11:8]};
        end
        default: begin
        end
      endcase
      d.rdata = {24'h000000, rd};
    end

    // Bus: address phase.
    taken = I_HSEL && I_HTRANS[1] && I_HREADY && (I_HSIZE == 3'h2);
    d.ap_write = taken && I_HWRITE;
    d.rd_wait = taken && !I_HWRITE;
    if (taken) begin
      d.ap_addr = I_HADDR[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter.
    if (!q.tx_en) begin
      d.tx_st = TX_IDLE;
      d.txd = 1'b1;
    end else if (tx_tick) begin
      unique case (q.tx_st)
        TX_IDLE, TX_STOP: begin
          if (q.tx_st == TX_STOP && q.stop2 && !q.tx_sb) begin
            d.tx_sb = 1'b1;
          end else if (d.tx_buf_v) begin
            d.txd = 1'b0;
            d.tx_sh = d.tx_buf & mask;
            d.tx_par = (^(d.tx_buf & mask)) ^ q.par_odd;
            d.tx_buf_v = 1'b0;
            d.tx_st = TX_START;
          end else begin
            d.txd = 1'b1;
            d.tx_st = TX_IDLE;
            if (q.tx_st == TX_STOP) begin
              d.txc = 1'b1;
            end
          end
        end
        TX_START: begin
          d.txd = q.tx_sh[0];
          d.tx_sh = q.tx_sh >> 1;
          d.tx_bi = 4'h1;
          d.tx_st = TX_DATA;
        end
        TX_DATA: begin
          if (q.tx_bi < nbits) begin
            d.txd = q.tx_sh[0];
            d.tx_sh = q.tx_sh >> 1;
            d.tx_bi = q.tx_bi + 4'h1;
          end else if (q.par_en) begin
            d.txd = q.tx_par;
            d.tx_st = TX_PAR;
          end else begin
            d.txd = 1'b1;
            d.tx_sb = 1'b0;
            d.tx_st = TX_STOP;
          end
        end
        TX_PAR: begin
          d.txd = 1'b1;
          d.tx_sb = 1'b0;
          d.tx_st = TX_STOP;
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver.
    // States per bit.
    ph_last = q.sync_sel ? PH_LAST_SYNC : (q.u2x ? PH_LAST_DBL : PH_LAST_NORM);
    ph_half = q.u2x ? PH_HALF_DBL : PH_HALF_NORM;
    bit_now = q.sync_sel ? (rx_tick & rx_sample) : (rx_tick && q.rx_ph == ph_last);
    if (!q.rx_en) begin
      d.rx_st = RX_IDLE;
    end else if (rx_tick) begin
      unique case (q.rx_st)
        RX_IDLE: begin
          if (!s && (!q.sync_sel || rx_sample)) begin
            d.rx_ph = 4'h0;
            d.rx_st = RX_START;
            start_ok = q.sync_sel;
          end
        end
        RX_START: begin
          if (q.rx_ph == ph_half) begin
            d.rx_st = s ? RX_IDLE : RX_DATA;
            start_ok = ~s;
            d.rx_ph = 4'h0;
          end else begin
            d.rx_ph = q.rx_ph + 4'h1;
          end
        end
        RX_DATA, RX_PAR, RX_STOP: begin
          d.rx_ph = bit_now ? 4'h0 : q.rx_ph + 4'h1;
          if (bit_now && q.rx_st == RX_DATA) begin
            d.rx_sh[q.rx_bi] = s;
            d.rx_par = q.rx_par ^ s;
            d.rx_bi = q.rx_bi + 4'h1;
            if (q.rx_bi == nbits - 4'h1) begin
              d.rx_st = q.par_en ? RX_PAR : RX_STOP;
            end
          end else if (bit_now && q.rx_st == RX_PAR) begin
            d.rx_pe = s ^ q.rx_par ^ q.par_odd;
            d.rx_st = RX_STOP;
          end else if (bit_now) begin
            frame_done = 1'b1;
            word = {~s, q.ovr_pend, q.rx_pe, q.rx_sh};
            d.ovr_pend = 1'b0;
            d.rx_st = RX_IDLE;
          end
        end
      endcase
    end
    if (start_ok) begin
      d.rx_st = RX_DATA;
      d.rx_sh = 9'h000;
      d.rx_bi = 4'h0;
      d.rx_par = 1'b0;
      d.rx_pe = 1'b0;
      if (q.rx_pend) begin
        d.rx_pend = 1'b0;
        d.ovr_pend = 1'b1;
      end
    end

    // Receive FIFO.
    if (d.rx_pend && cnt_t != 2'h2) begin
      d.fifo[d.rd_ptr ^ cnt_t[0]] = q.rx_pend_w;
      cnt_t = cnt_t + 2'h1;
      d.rx_pend = 1'b0;
    end
    if (frame_done) begin
      if (cnt_t != 2'h2) begin
        d.fifo[d.rd_ptr ^ cnt_t[0]] = word;
        cnt_t = cnt_t + 2'h1;
      end else begin
        d.rx_pend = 1'b1;
        d.rx_pend_w = word;
      end
    end
    d.cnt = cnt_t;
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      q <= '0;
      q.txd <= 1'b1;
      q.csz_lo <= CSZ_LO_RST;
      q.div <= DIV_RST;
      q.tx_st <= TX_IDLE;
      q.rx_st <= RX_IDLE;
      q.rxd_sync <= 2'h3;
    end else if (I_CE) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign O_HREADYOUT = ~q.rd_wait;
  assign O_HRDATA = q.rdata;
  assign O_HRESP = 1'b0;
  assign O_TXD = q.txd;
  // Pin driven only in sync master.
  assign O_XCK = xck_out;
  assign O_XCK_OE = q.sync_sel & q.xck_dir;
  assign O_IRQ_RXC = (q.cnt != 2'h0);
  assign O_IRQ_UDRE = ~q.tx_buf_v;
  assign O_IRQ_TXC = q.txc;

endmodule : usart_core
`default_nettype wire

// [verilog/usart_pkg.sv]
// Constants, register map, field positions and state codes of the USART core.
// Assumes a single 20 MHz system clock and an AHB-Lite register port.
//
// Contract
// - Down-counter baud generator, reload on zero/low write
// - Twelve-bit divisor, any value 0 to 4095
// - Transmit clock is baud divided 2/8/16
// - Normal async rate is fosc/16(div+1)
// - Double speed: divide 8, 8 samples
// - Baud generator clocks async and sync master
// - Double speed bit only affects async
// - Four clock modes from sync, direction and double speed
// - Transfer clock pin used only in sync
// - Slave clock synchronised then edge detected
// - Two-entry receive FIFO, each read pops one
// - Error flags and ninth bit queued per entry
// - Shift register holds third char until start
// - Single transmit buffer, frames back to back
// - Receiver flags frame, overrun, parity errors
// - 5 to 9 data, 1/2 stop, parity
// - Three requests: tx done, tx empty, rx done
// - Sync: polarity picks change/sample edges
// - Low start, LSB first, parity, high stop
// - Parity is XOR of data, inverted odd
package usart_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CSA = 8'h04;
  localparam logic [7:0] OFS_CSB = 8'h08;
  localparam logic [7:0] OFS_CSC = 8'h0c;
  localparam logic [7:0] OFS_BDL = 8'h10;
  localparam logic [7:0] OFS_BDH = 8'h14;

  // Bits of ctrl_status_a.
  localparam int CSA_RXC = 7;
  localparam int CSA_TXC = 6;
  localparam int CSA_UDRE = 5;
  localparam int CSA_FE = 4;
  localparam int CSA_DOR = 3;
  localparam int CSA_PE = 2;
  localparam int CSA_U2X = 1;

  // Bits of the second control register.
  localparam int CSB_RXEN = 4;
  localparam int CSB_TXEN = 3;
  localparam int CSB_CSZ_HI = 2;
  localparam int CSB_RECEIVED_NINTH_BIT = 1;
  localparam int CSB_TXB8 = 0;

  // Bits of ctrl_status_c.
  localparam int CSC_XDIR = 7;
  localparam int CSC_SYNC = 6;
  localparam int CSC_PEN = 5;
  localparam int CSC_PODD = 4;
  localparam int CSC_STOP2 = 3;
  localparam int CSC_CSZ_MSB = 2;
  localparam int CSC_CSZ_LSB = 1;
  localparam int CSC_POL = 0;

  // Receive FIFO entry layout.
  localparam int ENT_FE = 11;
  localparam int ENT_DOR = 10;
  localparam int ENT_PE = 9;
  localparam int ENT_W = 12;

  // Reset values.
  localparam logic [1:0] CSZ_LO_RST = 2'h3;
  localparam logic [11:0] DIV_RST = 12'h000;

  // Character size.
  localparam logic [3:0] NBITS_MIN = 4'h5;
  localparam logic [3:0] NBITS_MAX = 4'h9;

  // Divisors and samples per bit.
  localparam int SPS_NORMAL = 16;
  localparam int SPS_DOUBLE = 8;
  localparam int SPS_SYNC = 2;
  localparam logic [3:0] PH_LAST_NORM = 4'(SPS_NORMAL - 1);
  localparam logic [3:0] PH_LAST_DBL = 4'(SPS_DOUBLE - 1);
  localparam logic [3:0] PH_LAST_SYNC = 4'(SPS_SYNC - 1);
  localparam logic [3:0] PH_HALF_NORM = 4'(SPS_NORMAL / 2 - 1);
  localparam logic [3:0] PH_HALF_DBL = 4'(SPS_DOUBLE / 2 - 1);

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PAR = 5'h08,
    TX_STOP = 5'h10
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } rx_state_t;

endpackage : usart_pkg

// [verilog/usart_clock_gen.sv]
// Baud generator, transmit prescaler and transfer clock logic of the USART.
// Assumes the transfer clock input comes straight from a pin.
`timescale 1ns/100ps
`default_nettype none
module usart_clock_gen import usart_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [11:0] i_div,
  input wire logic i_div_reload,
  input wire logic i_sync_sel,
  input wire logic i_double_speed,
  input wire logic i_xck_master,
  input wire logic i_clock_polarity,
  input wire logic i_xck,
  output logic o_xck,
  output logic o_tx_tick,
  output logic o_rx_tick,
  output logic o_rx_sample
);

  typedef struct packed {
    logic [11:0] cnt;
    logic [3:0] pre;
    logic transfer_clock_pin;
    logic [2:0] xs;
  } cg_state_t;

  cg_state_t q;
  cg_state_t d;
  logic baud;
  logic rise;
  logic fall;
  logic tx_async;
  logic [3:0] pre_last;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    baud = (q.cnt == 12'h000);
    if (i_div_reload || baud) begin
      d.cnt = i_div;
    end else begin
      d.cnt = q.cnt - 12'h001;
    end
    d.xs = {q.xs[1:0], i_xck};
    if (i_sync_sel && i_xck_master && baud) begin
      d.transfer_clock_pin = ~q.transfer_clock_pin;
    end
    rise = i_xck_master ? (baud & ~q.transfer_clock_pin) : (q.xs[1] & ~q.xs[2]);
    fall = i_xck_master ? (baud & q.transfer_clock_pin) : (~q.xs[1] & q.xs[2]);
    pre_last = i_double_speed ? PH_LAST_DBL : PH_LAST_NORM;
    tx_async = baud && (q.pre >= pre_last);
    if (baud) begin
      d.pre = tx_async ? 4'h0 : q.pre + 4'h1;
    end
    o_tx_tick = i_sync_sel ? (i_clock_polarity ? fall : rise) : tx_async;
    o_rx_tick = i_sync_sel ? (rise | fall) : baud;
    o_rx_sample = i_sync_sel & (i_clock_polarity ? rise : fall);
    o_xck = q.transfer_clock_pin;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

endmodule : usart_clock_gen
`default_nettype wire

// [sim/usart_core_asserts.sv]
// Port assertions for the USART core, bound into every instance.
// Assumes one AHB-Lite master and hready fed back from hreadyout.
`timescale 1ns/100ps
`default_nettype none
module usart_core_asserts import usart_pkg::*; (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic I_HREADY,
  input wire logic O_HREADYOUT,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_HRESP,
  input wire logic O_TXD,
  input wire logic O_XCK,
  input wire logic O_XCK_OE,
  input wire logic O_IRQ_RXC,
  input wire logic O_IRQ_UDRE,
  input wire logic O_IRQ_TXC
);
  logic acc;
  logic wr_q;
  logic pop_q;
  assign acc = I_CE && I_HSEL && I_HTRANS[1] && I_HREADY && I_HSIZE == 3'h2;
  always_ff @(posedge I_CLK) begin
    wr_q <= !I_RST && acc && I_HWRITE;
    pop_q <= !I_RST && acc && !I_HWRITE && I_HADDR[7:0] == OFS_DATA;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  property p_rd_wait;
    acc && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("Read wait state wrong.");
  property p_wr_nowait;
    acc && I_HWRITE |=> O_HREADYOUT;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("Write was stalled.");
  property p_rst_vals;
    $fell(I_RST) |-> O_TXD && O_IRQ_UDRE && !O_IRQ_RXC && !O_IRQ_TXC && !O_XCK_OE;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("Reset state wrong.");
  property p_rd_hi;
    O_HREADYOUT |-> O_HRDATA[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("Read data upper bits set.");
  property p_okay;
    I_CE |-> !O_HRESP;
  endproperty
  a_okay: assert property (p_okay) else $error("Error response given.");
  property p_txc_hold;
    O_IRQ_TXC && !wr_q |=> O_IRQ_TXC;
  endproperty
  a_txc_hold: assert property (p_txc_hold) else $error("Done flag lost.");
  property p_rxc_pop;
    $fell(O_IRQ_RXC) |-> pop_q || $past(pop_q);
  endproperty
  a_rxc_pop: assert property (p_rxc_pop) else $error("Receive flag fell alone.");
  property p_xck_idle;
    !O_XCK_OE && $past(!O_XCK_OE) |-> $stable(O_XCK);
  endproperty
  a_xck_idle: assert property (p_xck_idle) else $error("Clock pin moved.");
  property p_txc_stop;
    $rose(O_IRQ_TXC) |-> O_TXD;
  endproperty
  a_txc_stop: assert property (p_txc_stop) else $error("Done before stop.");
  c_read: cover property (acc && !I_HWRITE);
  c_pop: cover property ($fell(O_IRQ_RXC));
  c_done: cover property ($rose(O_IRQ_TXC));
endmodule : usart_core_asserts
bind usart_core usart_core_asserts u_asserts (
  .I_CLK, .I_RST, .I_CE, .I_HSEL, .I_HADDR, .I_HTRANS, .I_HWRITE, .I_HSIZE,
  .I_HREADY, .O_HREADYOUT, .O_HRDATA, .O_HRESP, .O_TXD, .O_XCK, .O_XCK_OE,
  .O_IRQ_RXC, .O_IRQ_UDRE, .O_IRQ_TXC
);
`default_nettype wire

// [sim/usart_link_peer.sv]
// Remote serial device: decodes frames from the core and echoes each back.
// Assumes eight data bits, no parity, one stop bit, bit time in clocks.
`timescale 1ns/100ps
`default_nettype none
module usart_link_peer (
  input wire logic i_clk,
  input wire logic i_txd,
  input wire logic [31:0] i_bit,
  output logic o_rxd,
  output int o_n
);
  logic [7:0] q[$];
  logic [7:0] got;
  initial begin
    got = 8'h00;
    forever begin
      @(negedge i_txd);
      repeat (i_bit / 2) @(posedge i_clk);
      for (int k = 0; k < 8; k++) begin
        repeat (i_bit) @(posedge i_clk);
        got[k] = i_txd;
      end
      repeat (i_bit) @(posedge i_clk);
      q.push_back(got);
    end
  end
  initial begin
    logic [7:0] b;
    o_rxd = 1'b1;
    o_n = 0;
    forever begin
      @(posedge i_clk);
      if (q.size() > 0) begin
        b = q.pop_front();
        o_rxd <= 1'b0;
        repeat (i_bit) @(posedge i_clk);
        for (int k = 0; k < 8; k++) begin
          o_rxd <= b[k];
          repeat (i_bit) @(posedge i_clk);
        end
        o_rxd <= 1'b1;
        repeat (i_bit) @(posedge i_clk);
        o_n <= o_n + 1;
      end
    end
  end
endmodule : usart_link_peer
`default_nettype wire

// [sim/usart_clock_and_rx_buffering_tb_top.sv]
// Self-checking bench of the USART core with an echoing serial peer.
// Assumes the checker is bound to the core and hready is fed back.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); \
  end \
end
module usart_clock_and_rx_buffering_tb_top import usart_pkg::*; ;
  typedef struct packed {logic [7:0] dv; logic dbl; logic [7:0] dat; logic [7:0] len;} row_t;
  row_t rows [4] = '{'{8'h00, 1'b0, 8'ha5, 8'h10}, '{8'h02, 1'b0, 8'h3b, 8'h30},
                     '{8'h00, 1'b1, 8'hc7, 8'h08}, '{8'h04, 1'b1, 8'hff, 8'h28}};
  logic clk, rst, hsel, hwrite, hrdy, txd, rxd, transfer_clock_pin, oe, rxc, udre, xin;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [5:0] ev;
  int pbit, pn, tgt, n, n_fail, compares;
  assign ev = {!txd, !transfer_clock_pin, transfer_clock_pin, pn >= tgt, udre, rxc};
  usart_core DUT (
    .I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hrdy), .I_RXD(rxd), .I_XCK(xin), .O_HREADYOUT(hrdy), .O_HRDATA(hrdata),
    .O_HRESP(), .O_TXD(txd), .O_XCK(transfer_clock_pin), .O_XCK_OE(oe), .O_IRQ_RXC(rxc),
    .O_IRQ_UDRE(udre), .O_IRQ_TXC()
  );
  usart_link_peer PEER (.i_clk(clk), .i_txd(txd), .i_bit(pbit), .o_rxd(rxd), .o_n(pn));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic wt(input int s);
    int t;
    t = 0;
    while (ev[s] !== 1'b1 && t < 9000) begin
      @(posedge clk);
      t++;
    end
    if (t >= 9000) begin
      n_fail++;
      close_out();
    end
  endtask : wt
  task automatic span(input int s);
    wt(s);
    n = 1;
    @(posedge clk);
    while (ev[s] === 1'b1 && n < 900) begin
      n++;
      @(posedge clk);
    end
  endtask : span
  task automatic go_rdy();
    int t;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (hrdy !== 1'b1 && t < 50);
    if (hrdy !== 1'b1) begin
      n_fail++;
      close_out();
    end
  endtask : go_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    go_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    go_rdy();
    rd = hrdata;
  endtask : bus
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
    xin = 1'b0;
    {pbit, tgt, n_fail, compares} = {32'd16, 96'd0};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b1, OFS_CSB, 32'h18);
    foreach (rows[i]) begin
      bus(1'b1, OFS_BDH, 32'h0);
      bus(1'b1, OFS_BDL, {24'h0, rows[i].dv});
      bus(1'b1, OFS_CSA, {30'h10, rows[i].dbl, 1'b0});
      pbit = int'(rows[i].len);
      tgt = pn + 1;
      bus(1'b1, OFS_DATA, {24'h0, rows[i].dat});
      span(5);
      `CHK("start bit clocks", rows[i].len, n)
      wt(2);
      wt(0);
      bus(1'b0, OFS_CSA, 32'h0);
      `CHK("status", 8'he0, rd[7:0] & 8'hfc)
      bus(1'b0, OFS_DATA, 32'h0);
      `CHK("rx data", rows[i].dat, rd[7:0])
    end
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("txd idle", 1'b1, txd)
    bus(1'b0, OFS_CSA, 32'h0);
    `CHK("csa reset", 32'h20, rd)
    bus(1'b0, OFS_CSC, 32'h0);
    `CHK("csc reset", 32'h06, rd)
    bus(1'b1, OFS_BDH, 32'hff);
    bus(1'b0, OFS_BDH, 32'h0);
    `CHK("divisor high", 32'h0f, rd)
    bus(1'b1, 8'h18, 32'hff);
    bus(1'b0, 8'h18, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b1, OFS_BDH, 32'h0);
    bus(1'b1, OFS_CSB, 32'h18);
    pbit = 16;
    for (int m = 3; m < 5; m++) begin
      tgt = pn + m;
      for (int j = 0; j < m; j++) begin
        @(posedge clk);
        wt(1);
        bus(1'b1, OFS_DATA, {24'h0, 8'h31 + 8'(j)});
      end
      wt(2);
      for (int j = 0; j < 3; j++) begin
        bus(1'b0, OFS_CSA, 32'h0);
        `CHK("overrun", m == 4 && j == 2, rd[CSA_DOR])
        bus(1'b0, OFS_DATA, 32'h0);
        `CHK("fifo data", 8'h31 + 8'((m == 4 && j == 2) ? 3 : j), rd[7:0])
      end
      `CHK("fifo empty", 1'b0, rxc)
    end
    bus(1'b1, OFS_BDL, 32'h2);
    bus(1'b1, OFS_CSA, 32'h0);
    bus(1'b1, OFS_CSC, 32'hc6);
    @(posedge clk);
    `CHK("xck master drive", 1'b1, oe)
    wt(4);
    span(3);
    `CHK("xck half period", 3, n)
    bus(1'b1, OFS_CSC, 32'h46);
    @(posedge clk);
    `CHK("xck slave drive", 1'b0, oe)
    fork
      repeat (400) begin
        repeat (4) @(posedge clk);
        xin <= ~xin;
      end
    join_none
    bus(1'b1, OFS_DATA, 32'ha5);
    span(5);
    `CHK("slave start clocks", 8, n)
    close_out();
  end
endmodule : usart_clock_and_rx_buffering_tb_top
`default_nettype wire
